// ===== verilog/cws_pkg.sv
// Constants and types shared by the control write sequencer files.
// Assumes a single 20 MHz clock and one register access per cycle.
package cws_pkg;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ENA_IDX = 8'h6c;
  localparam logic [7:0] ADDR_STEP_A = 8'h6d;
  localparam logic [7:0] ADDR_STEP_B = 8'h6e;
  localparam logic [7:0] ADDR_LAUNCH = 8'h6f;
  localparam logic [7:0] ADDR_STATUS = 8'h70;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENA_BIT = 8;
  localparam int LOAD_IDX_HI = 4;
  localparam int WIDTH_HI = 14;
  localparam int WIDTH_LO = 12;
  localparam int LSB_HI = 11;
  localparam int LSB_LO = 8;
  localparam int TADDR_HI = 7;
  localparam int EOS_BIT = 14;
  localparam int DELAY_HI = 11;
  localparam int DELAY_LO = 8;
  localparam int VALUE_HI = 7;
  localparam int ABORT_BIT = 9;
  localparam int LAUNCH_BIT = 8;
  localparam int LAUNCH_IDX_HI = 5;
  localparam int RECENT_HI = 9;
  localparam int RECENT_LO = 4;
  localparam int BUSY_BIT = 0;

  // ----------------------------------------------------------------
  // Sequence memory map
  // ----------------------------------------------------------------
  localparam int RAM_DEPTH = 32;
  localparam int ROM_DEPTH = 17;
  localparam logic [5:0] ROM_FIRST = 6'h20;
  localparam logic [5:0] ROM_LAST = 6'h30;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_ENABLE = 1'b0;
  localparam logic [4:0] RST_LOAD_IDX = 5'h00;
  localparam logic [14:0] RST_STEP_A = 15'h0000;
  localparam logic [12:0] RST_STEP_B = 13'h0000;
  localparam logic [5:0] RST_IDX = 6'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Step timing
  // ----------------------------------------------------------------
  localparam real STEP_UNIT_US = 62.5;
  localparam real CLK_PERIOD_NS = 50.0;
  localparam int STEP_UNIT_CYCLES = int'(STEP_UNIT_US * 1000.0 / CLK_PERIOD_NS);
  localparam logic [15:0] DELAY_BASE_UNITS = 16'h0008;

  // ----------------------------------------------------------------
  // Step layout
  // ----------------------------------------------------------------
  typedef struct packed {
    logic eos;
    logic [3:0] delay;
    logic [7:0] value;
    logic [2:0] width;
    logic [3:0] lsb;
    logic [7:0] addr;
  } cws_step_t;

  localparam int STEP_BITS = 28;
  // Default fixed entry: a harmless one-bit write that ends the sequence
  localparam logic [STEP_BITS-1:0] ROM_FILL_STEP = 28'h8000000;

endpackage

// ===== verilog/cws_seq_if.sv
// Carrier between the sequencer core, its step memory and its step timer.
// Assumes all three parts run on the same clock.
interface cws_seq_if;
  logic ld_en;
  logic [4:0] ld_idx;
  cws_pkg::cws_step_t ld_step;
  logic [5:0] rd_idx;
  cws_pkg::cws_step_t rd_step;
  logic rd_valid;
  logic tm_start;
  logic [3:0] tm_code;
  logic tm_done;

  modport core (
    output ld_en, ld_idx, ld_step, rd_idx, tm_start, tm_code,
    input rd_step, rd_valid, tm_done
  );
  modport store (
    input ld_en, ld_idx, ld_step, rd_idx,
    output rd_step, rd_valid
  );
  modport timer (
    input tm_start, tm_code,
    output tm_done
  );
endinterface

// ===== verilog/cws_step_store.sv
// Step memory: 32 loadable entries followed by 17 fixed entries.
// Assumes loads and reads come from the core on the same clock.
module cws_step_store #(
  parameter logic [cws_pkg::ROM_DEPTH*cws_pkg::STEP_BITS-1:0] ROM_IMAGE =
    {cws_pkg::ROM_DEPTH{cws_pkg::ROM_FILL_STEP}}
) (
  input wire logic mclk,
  input wire logic rst_n,
  cws_seq_if.store sif
);

  cws_pkg::cws_step_t ram [cws_pkg::RAM_DEPTH];
  logic [4:0] rom_sel;

  // ----------------------------------------------------------------
  // Loadable entries
  // ----------------------------------------------------------------
  for (genvar i = 0; i < cws_pkg::RAM_DEPTH; i++)
  begin : g_ram
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
        ram[i] <= '0;
      else if (sif.ld_en && sif.ld_idx == 5'(i))
        ram[i] <= sif.ld_step;
    end
  end

  // ----------------------------------------------------------------
  // Read side
  // ----------------------------------------------------------------
  assign rom_sel = 5'(sif.rd_idx - cws_pkg::ROM_FIRST);

  always_comb
  begin
    sif.rd_valid = (sif.rd_idx <= cws_pkg::ROM_LAST);
    if (sif.rd_idx < cws_pkg::ROM_FIRST)
      sif.rd_step = ram[sif.rd_idx[4:0]];
    else if (sif.rd_idx <= cws_pkg::ROM_LAST)
      sif.rd_step = cws_pkg::cws_step_t'(
        ROM_IMAGE[rom_sel*cws_pkg::STEP_BITS +: cws_pkg::STEP_BITS]);
    else
      sif.rd_step = '0;
  end

endmodule

// ===== verilog/cws_step_timer.sv
// Step timer: measures the whole period of one step from its start pulse.
// Assumes the start pulse lasts one cycle; a new start reloads the count.
module cws_step_timer #(
  parameter int UNIT_CYCLES = cws_pkg::STEP_UNIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  cws_seq_if.timer sif
);

  logic [15:0] units;
  logic [31:0] remain;
  logic running;

  // Step length in units of UNIT_CYCLES
  assign units = 16'(16'h0001 << sif.tm_code) + cws_pkg::DELAY_BASE_UNITS;

  // Period is UNIT_CYCLES * (2^code + 8) cycles from one start to the next;
  // the start cycle and the done cycle are part of it, hence the two taken off
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      remain <= 32'h00000000;
      running <= 1'b0;
    end
    else if (sif.tm_start)
    begin
      remain <= 32'(UNIT_CYCLES) * {16'h0000, units} - 32'h00000002;
      running <= 1'b1;
    end
    else if (running)
    begin
      if (remain == 32'h00000000)
        running <= 1'b0;
      else
        remain <= remain - 32'h00000001;
    end
  end

  assign sif.tm_done = running && remain == 32'h00000000;

endmodule

// ===== verilog/cws_sequencer.sv
// Control write sequencer: step registers, launch control, step execution.
// Assumes the serial control interface delivers decoded register accesses
// on mclk, and the control register file answers a read address in the
// same cycle (ctl_rdata follows ctl_raddr combinationally).

// How it works
// - Sequencer runs only while the enable bit is one.
// - Any update of either step register copies the step into the indexed RAM entry.
// - Width code plus one gives the written field width, one to eight bits.
// - Position field places the field LSB at bit zero to fifteen.
// - Each step targets the control register addressed by its 8-bit address field.
// - A step carrying the last marker stops the sequencer after it runs.
// - Each step lasts 62.5 us times two to the wait code plus eight.
// - Value bits above the configured width are ignored.
// - Writing one to abort stops the run at once and frees the bus.
// - Writing one to launch starts execution at the launch index.
// - Steps run consecutively until a step with the last marker, or fixed entry 48, completes.
// - The launch bit clears itself when the sequence completes.
// - Index 0-31 are RAM, 32-48 fixed entries, 49-63 reserved.
// - Status bits 9:4 show the most recently accessed entry index.
// - Status bit 0 reads one while running, zero when idle.
// - Control register writes from the host are refused while running.
module cws_sequencer #(
  parameter int UNIT_CYCLES = cws_pkg::STEP_UNIT_CYCLES,
  parameter logic [cws_pkg::ROM_DEPTH*cws_pkg::STEP_BITS-1:0] ROM_IMAGE =
    {cws_pkg::ROM_DEPTH{cws_pkg::ROM_FILL_STEP}}
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic [15:0] host_rdata,
  output logic ctl_wr,
  output logic [7:0] ctl_addr,
  output logic [15:0] ctl_wdata,
  output logic [7:0] ctl_raddr,
  input wire logic [15:0] ctl_rdata,
  output logic ctl_locked
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_MERGE = 4'b0100,
    ST_WAIT = 4'b1000
  } cws_state_t;

  cws_state_t state;
  cws_state_t next_state;

  logic seq_enable;
  logic [4:0] step_load_index;
  logic [14:0] step_a;
  logic [12:0] step_b;
  logic seq_launch;
  logic [5:0] seq_launch_index;
  logic [5:0] seq_recent_index;
  logic seq_running;
  logic [5:0] cur_idx;
  cws_pkg::cws_step_t cur_step;
  logic load_pending;

  logic wr_ena;
  logic wr_step_a;
  logic wr_step_b;
  logic wr_launch;
  logic own_addr;
  logic abort_req;
  logic launch_req;
  logic launch_ok;
  logic stop_now;
  logic step_finish;
  logic seq_done;

  logic [7:0] field_mask;
  logic [15:0] place_mask;
  logic [15:0] place_data;
  logic [15:0] merged;

  cws_seq_if sif ();

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  assign own_addr = host_addr >= cws_pkg::ADDR_ENA_IDX && host_addr <= cws_pkg::ADDR_STATUS;
  // Only the launch register stays writable while running, so abort works
  assign wr_ena = host_wr && host_addr == cws_pkg::ADDR_ENA_IDX && !seq_running;
  assign wr_step_a = host_wr && host_addr == cws_pkg::ADDR_STEP_A && !seq_running;
  assign wr_step_b = host_wr && host_addr == cws_pkg::ADDR_STEP_B && !seq_running;
  assign wr_launch = host_wr && host_addr == cws_pkg::ADDR_LAUNCH;

  assign abort_req = wr_launch && host_wdata[cws_pkg::ABORT_BIT];
  assign launch_req = wr_launch && host_wdata[cws_pkg::LAUNCH_BIT] && !seq_running;
  // Reserved indices and a disabled sequencer make the launch a no-op
  assign launch_ok = launch_req && !abort_req && seq_enable
    && host_wdata[cws_pkg::LAUNCH_IDX_HI:0] <= cws_pkg::ROM_LAST;
  // Enable writes are refused while running, so only an abort stops a run here
  assign stop_now = abort_req || !seq_enable;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      seq_enable <= cws_pkg::RST_ENABLE;
      step_load_index <= cws_pkg::RST_LOAD_IDX;
    end
    else if (wr_ena)
    begin
      seq_enable <= host_wdata[cws_pkg::ENA_BIT];
      step_load_index <= host_wdata[cws_pkg::LOAD_IDX_HI:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      step_a <= cws_pkg::RST_STEP_A;
    else if (wr_step_a)
      step_a <= host_wdata[cws_pkg::WIDTH_HI:0];
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      step_b <= cws_pkg::RST_STEP_B;
    else if (wr_step_b)
      step_b <= {host_wdata[cws_pkg::EOS_BIT], host_wdata[cws_pkg::DELAY_HI:0]};
  end

  // Copy into the sequence RAM one cycle after either step register changes
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      load_pending <= 1'b0;
    else
      load_pending <= wr_step_a || wr_step_b;
  end

  assign sif.ld_en = load_pending;
  assign sif.ld_idx = step_load_index;
  assign sif.ld_step = {step_b[12], step_b[11:8], step_b[7:0],
    step_a[14:12], step_a[11:8], step_a[7:0]};

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      seq_launch_index <= cws_pkg::RST_IDX;
    else if (wr_launch && !seq_running)
      seq_launch_index <= host_wdata[cws_pkg::LAUNCH_IDX_HI:0];
  end

  // Launch bit: set by an accepted launch, cleared on completion or stop
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      seq_launch <= 1'b0;
    else if (launch_ok)
      seq_launch <= 1'b1;
    else if (seq_done || (seq_running && stop_now))
      seq_launch <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Step execution
  // ----------------------------------------------------------------
  assign step_finish = state == ST_WAIT && sif.tm_done;
  // Last marker, or finishing the final fixed entry, ends the sequence
  assign seq_done = step_finish && (cur_step.eos || cur_idx == cws_pkg::ROM_LAST);

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (launch_ok)
          next_state = ST_FETCH;
      ST_FETCH:
        next_state = ST_MERGE;
      ST_MERGE:
        next_state = ST_WAIT;
      ST_WAIT:
        if (seq_done)
          next_state = ST_IDLE;
        else if (step_finish)
          next_state = ST_FETCH;
      default:
        next_state = ST_IDLE;
    endcase
    if (state != ST_IDLE && stop_now)
      next_state = ST_IDLE;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      seq_running <= 1'b0;
    else
      seq_running <= next_state != ST_IDLE;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      cur_idx <= cws_pkg::RST_IDX;
    else if (launch_ok)
      cur_idx <= host_wdata[cws_pkg::LAUNCH_IDX_HI:0];
    else if (step_finish)
      cur_idx <= cur_idx + 6'h01;
  end

  assign sif.rd_idx = cur_idx;
  assign sif.tm_start = state == ST_FETCH;
  assign sif.tm_code = sif.rd_step.delay;

  // Latch the step and present the target address for the read half
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_step <= '0;
      seq_recent_index <= cws_pkg::RST_IDX;
    end
    else if (state == ST_FETCH)
    begin
      cur_step <= sif.rd_step;
      seq_recent_index <= cur_idx;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctl_raddr <= 8'h00;
    else if (state == ST_FETCH)
      ctl_raddr <= sif.rd_step.addr;
  end

  // Field merge; bits placed above bit 15 fall off the register
  assign field_mask = 8'(8'hff >> (3'h7 - cur_step.width));
  assign place_mask = 16'({8'h00, field_mask} << cur_step.lsb);
  assign place_data = 16'({8'h00, cur_step.value & field_mask} << cur_step.lsb);
  assign merged = (ctl_rdata & ~place_mask) | place_data;

  // ----------------------------------------------------------------
  // Control register write port
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_wr <= 1'b0;
      ctl_addr <= 8'h00;
      ctl_wdata <= cws_pkg::RST_WORD;
    end
    else if (state == ST_MERGE && !stop_now)
    begin
      ctl_wr <= 1'b1;
      ctl_addr <= cur_step.addr;
      ctl_wdata <= merged;
    end
    else if (host_wr && !own_addr && !seq_running)
    begin
      ctl_wr <= 1'b1;
      ctl_addr <= host_addr;
      ctl_wdata <= host_wdata;
    end
    else
      ctl_wr <= 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      ctl_locked <= 1'b0;
    else
      ctl_locked <= next_state != ST_IDLE;
  end

  // ----------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      host_rdata <= cws_pkg::RST_WORD;
    else if (host_rd)
    begin
      unique case (host_addr)
        cws_pkg::ADDR_ENA_IDX:
          host_rdata <= {7'h00, seq_enable, 3'h0, step_load_index};
        cws_pkg::ADDR_STEP_A:
          host_rdata <= {1'b0, step_a};
        cws_pkg::ADDR_STEP_B:
          host_rdata <= {1'b0, step_b[12], 2'h0, step_b[11:0]};
        cws_pkg::ADDR_LAUNCH:
          host_rdata <= {6'h00, 1'b0, seq_launch, 2'h0, seq_launch_index};
        cws_pkg::ADDR_STATUS:
          host_rdata <= {6'h00, seq_recent_index, 3'h0, seq_running};
        default:
          host_rdata <= cws_pkg::RST_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Step memory and step timer
  // ----------------------------------------------------------------
  cws_step_store #(
    .ROM_IMAGE(ROM_IMAGE)
  ) u_store (
    .mclk(mclk),
    .rst_n(rst_n),
    .sif(sif.store)
  );

  cws_step_timer #(
    .UNIT_CYCLES(UNIT_CYCLES)
  ) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .sif(sif.timer)
  );

endmodule

// ===== dv/cws_sequencer_assertions.sv
// Port-level checker for the control write sequencer.
// Assumes it is bound into cws_sequencer and sees only its ports.
module cws_sequencer_assertions #(
  parameter int UNIT_CYCLES = 2
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_addr,
  input wire logic [15:0] ctl_wdata,
  input wire logic [7:0] ctl_raddr,
  input wire logic [15:0] ctl_rdata,
  input wire logic ctl_locked
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------
  // Helpers
  // ----------
  logic ena_q;
  logic is_launch;
  assign is_launch = host_wr && host_addr == 8'h6f && host_wdata[9:8] == 2'b01 && !ctl_locked;
  // Shadow of the enable bit, writable only while idle
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      ena_q <= 1'b0;
    else if (host_wr && host_addr == 8'h6c && !ctl_locked)
      ena_q <= host_wdata[8];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence s_run3;
    $rose(ctl_locked) ##1 ctl_locked [*2];
  endsequence
  sequence s_abort;
    ctl_locked && host_wr && host_addr == 8'h6f && host_wdata[9];
  endsequence

  // ----------
  // Properties
  // ----------
  launch_runs_a:
    assert property (is_launch && ena_q && host_wdata[5:0] <= 6'h30 |=> ctl_locked)
    else $error("launch did not start a run");
  disabled_idle_a:
    assert property (is_launch && !ena_q |=> !ctl_locked)
    else $error("run started while disabled");
  reserved_idx_a:
    assert property (is_launch && host_wdata[5:0] > 6'h30 |=> !ctl_locked)
    else $error("run started at reserved index");
  abort_stop_a:
    assert property (s_abort |=> !ctl_locked && !ctl_wr)
    else $error("abort did not stop the run");
  host_forward_a:
    assert property (!ctl_locked && host_wr && (host_addr < 8'h6c || host_addr > 8'h70)
      |=> ctl_wr && ctl_addr == $past(host_addr) && ctl_wdata == $past(host_wdata))
    else $error("idle host write not forwarded");
  first_step_a:
    assert property (s_run3 |-> ctl_wr)
    else $error("first step write missing");
  merge_target_a:
    assert property (ctl_wr && ctl_locked |-> ctl_addr == $past(ctl_raddr))
    else $error("step wrote other than read target");
  step_spacing_a:
    assert property (ctl_wr && ctl_locked |=> (!ctl_wr || !ctl_locked) [*8])
    else $error("step writes too close");
  busy_read_a:
    assert property (host_rd && host_addr == 8'h70 |=> host_rdata[0] == $past(ctl_locked))
    else $error("busy flag read wrong");
endmodule

bind cws_sequencer cws_sequencer_assertions #(.UNIT_CYCLES(UNIT_CYCLES)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd),
  .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
  .ctl_wr(ctl_wr), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
  .ctl_raddr(ctl_raddr), .ctl_rdata(ctl_rdata), .ctl_locked(ctl_locked)
);

// ===== dv/cws_ctl_regs_model.sv
// Model of the device control register file behind the sequencer.
// Assumes one write per cycle and a combinational read port.
module cws_ctl_regs_model (
  input wire logic mclk,
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_addr,
  input wire logic [15:0] ctl_wdata,
  input wire logic [7:0] ctl_raddr,
  output logic [15:0] ctl_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] regs [256];
  initial
    foreach (regs[i])
      regs[i] = 16'h0000;
  always @(posedge mclk)
    if (ctl_wr)
      regs[ctl_addr] <= ctl_wdata;
  assign ctl_rdata = regs[ctl_raddr];
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the control write sequencer.
// Assumes the checker file is compiled alongside for the bind.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, rst_n, host_wr, host_rd, ctl_wr, ctl_locked;
  logic [7:0] host_addr, ctl_addr, ctl_raddr;
  logic [15:0] host_wdata, host_rdata, ctl_wdata, ctl_rdata;
  int failures = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0, t1, t2;

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  cws_sequencer #(.UNIT_CYCLES(2)) u_cws_sequencer (
    .mclk(mclk), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .ctl_wr(ctl_wr), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
    .ctl_raddr(ctl_raddr), .ctl_rdata(ctl_rdata), .ctl_locked(ctl_locked)
  );
  cws_ctl_regs_model u_cws_ctl_regs_model (
    .mclk(mclk), .ctl_wr(ctl_wr), .ctl_addr(ctl_addr), .ctl_wdata(ctl_wdata),
    .ctl_raddr(ctl_raddr), .ctl_rdata(ctl_rdata)
  );

  // ----------
  // Tasks
  // ----------
  task complete_run;
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task chk_n(input int got, input int exp);
    cmp_count++;
    if (got != exp)
    begin
      failures++;
      $display("mismatch at %0t: cycles %0d expected %0d", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge mclk);
    host_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge mclk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge mclk);
    host_rd <= 1'b0;
    @(negedge mclk);
    chk(host_rdata, exp);
  endtask
  task wait_sig(input logic want_wr, output int t);
    int n;
    for (n = 0; n < 300; n++)
    begin
      @(negedge mclk);
      if (want_wr ? ctl_wr === 1'b1 : ctl_locked === 1'b0)
        break;
    end
    if (n == 300)
      chk_n(n, 0);
    t = cyc;
  endtask

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      failures++;
      complete_run;
    end
  end

  // ----------
  // Sequence
  // ----------
  initial
  begin
    rst_n = 1'b0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 8'h00;
    host_wdata = 16'h0000;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 8'h6c; a <= 8'h70; a++)
      rd(a[7:0], 16'h0000);
    rd(8'h10, 16'h0000);
    wr(8'h20, 16'h00ff);
    wr(8'h21, 16'h0123);
    wr(8'h00, 16'h0003);
    // Entry 0: 4 bits at bit 4 of 0x20, wait code 3, extra value bits set
    wr(8'h6c, 16'h0100);
    wr(8'h6d, 16'h3420);
    wr(8'h6e, 16'h03fa);
    // Entry 1: 8 bits at bit 12 of 0x21, last step
    wr(8'h6c, 16'h0101);
    wr(8'h6d, 16'h7c21);
    wr(8'h6e, 16'h40a5);
    rd(8'h6d, 16'h7c21);
    rd(8'h6e, 16'h40a5);
    wr(8'h6f, 16'h0100);
    wait_sig(1'b1, t0);
    rd(8'h70, 16'h0001);
    wr(8'h22, 16'hbeef);
    wr(8'h6c, 16'h0105);
    rd(8'h6f, 16'h0100);
    wait_sig(1'b1, t1);
    chk_n(t1 - t0, 32);
    wait_sig(1'b0, t2);
    chk_n(t2 - t1, 16);
    chk(u_cws_ctl_regs_model.regs[8'h20], 16'h00af);
    chk(u_cws_ctl_regs_model.regs[8'h21], 16'h5123);
    chk(u_cws_ctl_regs_model.regs[8'h22], 16'h0000);
    rd(8'h6c, 16'h0101);
    rd(8'h6f, 16'h0000);
    rd(8'h70, 16'h0010);
    // Fixed entry 32
    wr(8'h6f, 16'h0120);
    wait_sig(1'b0, t2);
    chk(u_cws_ctl_regs_model.regs[8'h00], 16'h0002);
    rd(8'h70, 16'h0200);
    wr(8'h6f, 16'h0131);
    rd(8'h70, 16'h0200);
    // Abort while the first step is pending
    wr(8'h6f, 16'h0100);
    wr(8'h6f, 16'h0200);
    @(posedge mclk);
    @(negedge mclk);
    chk({15'h0000, ctl_locked}, 16'h0000);
    chk(u_cws_ctl_regs_model.regs[8'h20], 16'h00af);
    rd(8'h6f, 16'h0000);
    // Launch with the sequencer disabled
    wr(8'h6c, 16'h0000);
    wr(8'h6f, 16'h0100);
    @(negedge mclk);
    chk({15'h0000, ctl_locked}, 16'h0000);
    rd(8'h6f, 16'h0000);
    complete_run;
  end
endmodule
